// File: core/ppm_pkg.sv
// Package for the power management control/status register bank.
// Operation
// - Wake status sets on every wake event held for two or more cycles, whatever the wake enable holds.
// - Writing one to wake status clears it and drops the wake output.
// - Wake output is only asserted while wake enable is set.
// - Wake enable survives primary reset; only global reset clears it.
// - Power state field reads the present state; a write sets a new one unless primary reset is asserted.
// - Data scale field always reads zero.
// - Data select field always reads zero and ignores writes.
// - Reserved bits of both registers read zero.
// - A write leaving D3hot for D0 issues an internal reset of the function's registers.
// - This control/status register keeps its contents through that internal reset.
// - Bus power/clock control enable bit always reads one.
// - D3hot secondary bus action bit reads one: secondary clock is stopped.
// - Secondary bus action bit has meaning only while the enable bit is one.
package ppm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_PM_CSR = 8'ha4;
    localparam logic [7:0] OFS_PM_BSE = 8'ha6;
    localparam logic [7:0] OFS_IRQ_STAT = 8'hb0;
    localparam logic [7:0] OFS_IRQ_MASK = 8'hb4;
    localparam int BIT_WAKE_STS = 15;
    localparam int BIT_WAKE_EN = 8;
    localparam int PS_LO = 0;
    localparam int PS_HI = 1;
    localparam logic [7:0] BSE_VALUE = 8'hc0;
    localparam int IRQ_W = 2;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_PSCHG = 1;

    typedef enum logic [1:0] {
        PS_D0 = 2'h0,
        PS_D1 = 2'h1,
        PS_D2 = 2'h2,
        PS_D3HOT = 2'h3
    } ppm_pstate_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ppm_bus_req_t;

    typedef struct packed {
        logic wake_sts;
        logic wake_en;
        ppm_pstate_t pstate;
        logic [IRQ_W-1:0] irq_sts;
        logic [IRQ_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
        logic func_rst;
        logic [2:0] wake_sync;
    } ppm_state_t;
endpackage

// File: core/ppm_csr.sv
// Power management control/status register bank for one socket function.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module ppm_csr (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PRIMARY_RESET,
    input wire ppm_pkg::ppm_bus_req_t BUS_REQ,
    output logic [ppm_pkg::DATA_W-1:0] BUS_RDATA,
    input wire logic WAKE_EVENT,
    output logic WAKE_OUT,
    output logic FUNC_RESET,
    output ppm_pkg::ppm_pstate_t POWER_STATE,
    output logic SEC_CLK_STOP,
    output logic IRQ
);
    import ppm_pkg::*;

    ppm_state_t st_r;
    ppm_state_t st_nxt;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic wake_evt;
    assign wake_evt = st_r.wake_sync[1] & st_r.wake_sync[2];

    always_comb begin
        st_nxt = st_r;
        st_nxt.wake_sync = {st_r.wake_sync[1:0], WAKE_EVENT};
        st_nxt.func_rst = 1'b0;
        st_nxt.rdata = '0;
        // Primary reset leaves the wake enable alone; it only drops power state.
        if (PRIMARY_RESET) begin
            st_nxt.pstate = PS_D0;
        end
        if (BUS_REQ.wr && hit(BUS_REQ.addr, OFS_PM_CSR)) begin
            if (BUS_REQ.wdata[BIT_WAKE_STS]) begin
                st_nxt.wake_sts = 1'b0;
            end
            st_nxt.wake_en = BUS_REQ.wdata[BIT_WAKE_EN];
            if (!PRIMARY_RESET) begin
                st_nxt.pstate = ppm_pstate_t'(BUS_REQ.wdata[PS_HI:PS_LO]);
                if (st_r.pstate == PS_D3HOT && BUS_REQ.wdata[PS_HI:PS_LO] == PS_D0) begin
                    // This register is not in the reset scope of the pulse.
                    st_nxt.func_rst = 1'b1;
                end
                if (BUS_REQ.wdata[PS_HI:PS_LO] != st_r.pstate) begin
                    st_nxt.irq_sts[IRQ_PSCHG] = 1'b1;
                end
            end
        end
        if (BUS_REQ.wr && hit(BUS_REQ.addr, OFS_IRQ_STAT)) begin
            st_nxt.irq_sts = st_r.irq_sts & ~BUS_REQ.wdata[IRQ_W-1:0];
        end
        if (BUS_REQ.wr && hit(BUS_REQ.addr, OFS_IRQ_MASK)) begin
            st_nxt.irq_mask = BUS_REQ.wdata[IRQ_W-1:0];
        end
        // A wake event in the same cycle as a clear wins over the clear.
        if (wake_evt) begin
            st_nxt.wake_sts = 1'b1;
            st_nxt.irq_sts[IRQ_WAKE] = 1'b1;
        end
        if (BUS_REQ.rd) begin
            if (hit(BUS_REQ.addr, OFS_PM_CSR)) begin
                // Data scale, data select and reserved bits stay zero.
                st_nxt.rdata[BIT_WAKE_STS] = st_r.wake_sts;
                st_nxt.rdata[BIT_WAKE_EN] = st_r.wake_en;
                st_nxt.rdata[PS_HI:PS_LO] = st_r.pstate;
            end else if (hit(BUS_REQ.addr, OFS_PM_BSE)) begin
                st_nxt.rdata[7:0] = BSE_VALUE;
            end else if (hit(BUS_REQ.addr, OFS_IRQ_STAT)) begin
                st_nxt.rdata[IRQ_W-1:0] = st_r.irq_sts;
            end else if (hit(BUS_REQ.addr, OFS_IRQ_MASK)) begin
                st_nxt.rdata[IRQ_W-1:0] = st_r.irq_mask;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign BUS_RDATA = st_r.rdata;
    assign WAKE_OUT = st_r.wake_sts & st_r.wake_en;
    assign FUNC_RESET = st_r.func_rst;
    assign POWER_STATE = st_r.pstate;
    // The action bit is constant one and the enable bit is constant one.
    assign SEC_CLK_STOP = BSE_VALUE[7] & BSE_VALUE[6] & (st_r.pstate == PS_D3HOT);
    assign IRQ = |(st_r.irq_sts & st_r.irq_mask);
endmodule
`default_nettype wire

// File: verification/ppm_csr_props.sv
// Concurrent checks on the power management register bank ports.
`timescale 1ns/10ps
`default_nettype none
module ppm_csr_props (
    input wire logic CORE_CLK, input wire logic RST, input wire logic PRIMARY_RESET,
    input wire ppm_pkg::ppm_bus_req_t BUS_REQ, input wire logic [31:0] BUS_RDATA,
    input wire logic WAKE_EVENT, input wire logic WAKE_OUT, input wire logic FUNC_RESET,
    input wire ppm_pkg::ppm_pstate_t POWER_STATE, input wire logic SEC_CLK_STOP
);
    import ppm_pkg::*;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    wire logic cw = BUS_REQ.wr && BUS_REQ.addr == OFS_PM_CSR;
    wire logic cr = BUS_REQ.rd && BUS_REQ.addr == OFS_PM_CSR;
    wire logic [1:0] wps = BUS_REQ.wdata[1:0];
    // Events sit in sync flops for a while, so a clear only holds after a quiet spell.
    sequence quiet_clr;
        !WAKE_EVENT [*5] ##0 cw && BUS_REQ.wdata[BIT_WAKE_STS];
    endsequence
    AST_BSE: assert property (BUS_REQ.rd && BUS_REQ.addr == OFS_PM_BSE
        |=> BUS_RDATA == 32'h000000c0) else $error("bad ext read");
    AST_CSR_ZERO: assert property (cr |=> (BUS_RDATA & 32'hffff7efc) == 32'h0)
        else $error("bad zero bits");
    AST_STATE_WR: assert property (cw && !PRIMARY_RESET |=> POWER_STATE == $past(wps))
        else $error("bad state");
    AST_FRST: assert property (cw && wps == 2'h0 && POWER_STATE == PS_D3HOT
        && !PRIMARY_RESET |-> ##[1:2] FUNC_RESET) else $error("no func reset");
    AST_CLK_STOP: assert property (SEC_CLK_STOP == (POWER_STATE == PS_D3HOT))
        else $error("bad clock stop");
    AST_EN_OFF: assert property (cw && !BUS_REQ.wdata[BIT_WAKE_EN] |=> !WAKE_OUT)
        else $error("wake while off");
    AST_STS_CLR: assert property (quiet_clr |=> ##1 !WAKE_OUT)
        else $error("wake after clear");
    AST_PRIMARY_RESET_INPUT_KEEP: assert property (WAKE_OUT && PRIMARY_RESET && !cw && !$past(cw)
        |=> WAKE_OUT) else $error("wake lost");
endmodule
bind ppm_csr ppm_csr_props ppm_csr_props_inst (.*);
`default_nettype wire

// File: verification/tb_pci_power_mgmt_csr.sv
// Self-checking bench for the power management register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_pci_power_mgmt_csr;
    import ppm_pkg::*;
    logic clk = 0, rst = 1, primary_reset_input = 0, ev = 0, rd_d = 0, wk, fr, sc, irq;
    logic [31:0] rdata, d, q[$];
    ppm_bus_req_t req = '0;
    ppm_pstate_t ps;
    int err_count = 0, checked = 0, pulses = 0;
    always #20 clk = ~clk;
    ppm_csr ppm_csr_inst (.CORE_CLK(clk), .RST(rst), .PRIMARY_RESET(primary_reset_input), .BUS_REQ(req),
        .BUS_RDATA(rdata), .WAKE_EVENT(ev), .WAKE_OUT(wk), .FUNC_RESET(fr),
        .POWER_STATE(ps), .SEC_CLK_STOP(sc), .IRQ(irq));
    task automatic chk(input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %0t got %h", $time, s);
        end
    endtask
    task automatic op(input logic w, r, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        req <= '{a, v, w, r};
        if (r) q.push_back(v);
    endtask
    task automatic wake;
        op(0, 0, 0, 0);
        ev <= 1;
        repeat (3) @(posedge clk);
        ev <= 0;
        repeat (6) @(posedge clk);
    endtask
    task automatic complete_run;
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        if (rd_d) chk(rdata, q.pop_front());
        rd_d <= req.rd;
        if (fr) pulses++;
    end
    initial begin
        #8000;
        err_count++;
        complete_run();
    end
    initial begin
        d = $urandom(32'h37252011);
        repeat (3) @(posedge clk);
        rst <= 0;
        op(0, 1, OFS_PM_CSR, 0);
        op(0, 1, OFS_PM_BSE, 32'hc0);
        op(0, 1, 8'h10, 0);
        for (int i = 0; i < 4; i++) begin
            d = $urandom & 32'hffff7efc | i;
            op(1, 0, OFS_PM_CSR, d);
            op(0, 1, OFS_PM_CSR, i);
            #1 chk({ps, sc}, {i[1:0], i == 3});
        end
        op(1, 0, OFS_PM_CSR, 32'h100);
        op(0, 1, OFS_PM_CSR, 32'h100);
        op(1, 0, OFS_IRQ_MASK, 1);
        wake();
        chk({wk, irq}, 3);
        primary_reset_input <= 1;
        op(0, 1, OFS_PM_CSR, 32'h8100);
        op(1, 0, OFS_PM_CSR, 32'h8100);
        primary_reset_input <= 0;
        op(1, 0, OFS_IRQ_STAT, 3);
        op(0, 1, OFS_PM_CSR, 32'h100);
        op(1, 0, OFS_PM_CSR, 0);
        chk(irq, 0);
        wake();
        chk({wk, irq}, 1);
        op(0, 1, OFS_PM_CSR, 32'h8000);
        op(0, 0, 0, 0);
        repeat (2) @(posedge clk);
        chk(pulses, 1);
        complete_run();
    end
endmodule
`default_nettype wire
